// ---- logic/crte_exec.sv ----
// Compare-and-skip, rotate and transfer execution unit with APB registers
`timescale 1ns/1ns
`default_nettype none

module crte_exec (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        pclk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             busy,
	output logic             skip_pulse
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	crte_pkg::crte_state_t                 state_reg;
	crte_pkg::crte_state_t                 state_next;
	crte_pkg::crte_instr_t                 instr_reg;
	crte_pkg::crte_mem_req_t               mem_req;
	logic [crte_pkg::NIB_W-1:0]            mem_q;
	logic [crte_pkg::NIB_W-1:0]            data_a_reg;
	logic                                  carry_flag;
	logic                                  compare_flag;
	logic                                  index_enable_flag;
	logic                                  row_pointer_enable;
	logic [crte_pkg::MADDR_W-1:0]          index_value;
	logic [crte_pkg::ROW_W-1:0]            memory_row_pointer;
	logic [crte_pkg::ROW_W-1:0]            register_row_pointer;
	logic [crte_pkg::MADDR_W-1:0]          mem_addr_reg;
	logic                                  skip_flag_reg;
	logic                                  skip_pulse_reg;
	logic                                  rd_pend_reg;
	logic                                  access;
	logic                                  wr_ok;
	logic                                  hit_instr;
	logic                                  hit_memdata;
	logic                                  mapped;
	logic [crte_pkg::MADDR_W-1:0]          m_addr;
	logic [crte_pkg::MADDR_W-1:0]          r_addr;
	logic [crte_pkg::ROW_W-1:0]            ind_row;
	logic [crte_pkg::NIB_W:0]              diff;
	logic                                  borrow;
	logic                                  skip_now;
	logic                                  is_compare;
	logic                                  exec_we;
	logic [crte_pkg::MADDR_W-1:0]          exec_waddr;
	logic [crte_pkg::NIB_W-1:0]            exec_wdata;

	// ------------------------------------------------------------------
	// APB decode and handshake
	// ------------------------------------------------------------------
	assign access      = psel && penable;
	assign hit_instr   = (paddr == crte_pkg::OFS_INSTR);
	assign hit_memdata = (paddr == crte_pkg::OFS_MEM_DATA);
	assign mapped      = hit_instr || hit_memdata || (paddr == crte_pkg::OFS_FLAGS)
		|| (paddr == crte_pkg::OFS_INDEX) || (paddr == crte_pkg::OFS_POINTERS)
		|| (paddr == crte_pkg::OFS_STATUS) || (paddr == crte_pkg::OFS_MEM_ADDR);
	assign busy        = (state_reg != crte_pkg::ST_IDLE);

	// Memory-touching accesses wait for the unit to go idle; a read
	// additionally waits one cycle for the registered memory data
	always_comb begin
		if (hit_memdata && !pwrite) begin
			pready = rd_pend_reg;
		end else if (pwrite && (hit_instr || hit_memdata)) begin
			pready = !busy;
		end else begin
			pready = 1'b1;
		end
	end

	assign pslverr = access && pready && !mapped;
	assign wr_ok   = access && pready && pwrite && pclk_en;

	// Read-wait marker for memory data reads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_pend_reg <= 1'b0;
		end else if (pclk_en) begin
			rd_pend_reg <= access && !pwrite && hit_memdata && !busy && !rd_pend_reg;
		end
	end

	// Read data mux, every source a flip-flop except busy, which is decoded from state_reg
	always_comb begin
		prdata = 32'h0000_0000;
		case (paddr)
			crte_pkg::OFS_INSTR:    prdata[15:0] = instr_reg;
			crte_pkg::OFS_FLAGS: begin
				prdata[crte_pkg::FLG_CARRY]   = carry_flag;
				prdata[crte_pkg::FLG_COMPARE] = compare_flag;
				prdata[crte_pkg::FLG_INDEX]   = index_enable_flag;
				prdata[crte_pkg::FLG_ROWPTR]  = row_pointer_enable;
			end
			crte_pkg::OFS_INDEX:    prdata[crte_pkg::MADDR_W-1:0] = index_value;
			crte_pkg::OFS_POINTERS: begin
				prdata[crte_pkg::PTR_REG_ROW +: crte_pkg::ROW_W] = register_row_pointer;
				prdata[crte_pkg::PTR_MEM_ROW +: crte_pkg::ROW_W] = memory_row_pointer;
			end
			crte_pkg::OFS_STATUS: begin
				prdata[crte_pkg::STS_BUSY] = busy;
				prdata[crte_pkg::STS_SKIP] = skip_flag_reg;
			end
			crte_pkg::OFS_MEM_ADDR: prdata[crte_pkg::MADDR_W-1:0] = mem_addr_reg;
			crte_pkg::OFS_MEM_DATA: prdata[crte_pkg::NIB_W-1:0] = mem_q;
			default:                prdata = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------------
	// Software-owned pointer and address registers
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			index_value          <= '0;
			memory_row_pointer   <= '0;
			register_row_pointer <= '0;
			mem_addr_reg         <= '0;
			index_enable_flag    <= 1'b0;
			row_pointer_enable   <= 1'b0;
		end else if (wr_ok) begin
			case (paddr)
				crte_pkg::OFS_INDEX:    index_value <= pwdata[crte_pkg::MADDR_W-1:0];
				crte_pkg::OFS_MEM_ADDR: mem_addr_reg <= pwdata[crte_pkg::MADDR_W-1:0];
				crte_pkg::OFS_POINTERS: begin
					register_row_pointer <= pwdata[crte_pkg::PTR_REG_ROW +: crte_pkg::ROW_W];
					memory_row_pointer   <= pwdata[crte_pkg::PTR_MEM_ROW +: crte_pkg::ROW_W];
				end
				crte_pkg::OFS_FLAGS: begin
					index_enable_flag  <= pwdata[crte_pkg::FLG_INDEX];
					row_pointer_enable <= pwdata[crte_pkg::FLG_ROWPTR];
				end
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Instruction register: a write here launches execution
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_reg <= crte_pkg::INSTR_RST;
		end else if (wr_ok && hit_instr) begin
			instr_reg <= pwdata[15:0];
		end
	end

	// ------------------------------------------------------------------
	// Address formation
	// ------------------------------------------------------------------
	// Index is ORed, not added, so no carry ripples into the row field
	assign m_addr = {instr_reg.row, instr_reg.col}
		| (index_enable_flag ? index_value : '0);
	assign r_addr = {register_row_pointer, instr_reg.nib};
	assign ind_row = row_pointer_enable ? memory_row_pointer : instr_reg.row;

	// ------------------------------------------------------------------
	// Sequencer: fetch A, fetch B, execute
	// ------------------------------------------------------------------
	always_comb begin
		case (state_reg)
			crte_pkg::ST_IDLE:    state_next = (wr_ok && hit_instr) ? crte_pkg::ST_FETCH_A
				: crte_pkg::ST_IDLE;
			crte_pkg::ST_FETCH_A: state_next = crte_pkg::ST_FETCH_B;
			crte_pkg::ST_FETCH_B: state_next = crte_pkg::ST_EXEC;
			crte_pkg::ST_EXEC:    state_next = crte_pkg::ST_IDLE;
			default:              state_next = crte_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= crte_pkg::ST_IDLE;
		end else if (pclk_en) begin
			state_reg <= state_next;
		end
	end

	// First operand captured once its read returns
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_a_reg <= '0;
		end else if (pclk_en && state_reg == crte_pkg::ST_FETCH_B) begin
			data_a_reg <= mem_q;
		end
	end

	// ------------------------------------------------------------------
	// Compare evaluation
	// ------------------------------------------------------------------
	assign diff   = {1'b0, data_a_reg} - {1'b0, instr_reg.nib};
	assign borrow = diff[crte_pkg::NIB_W];

	// An all-ones mask turns the AND into the nibble itself, so the
	// bits-clear test then matches the equal-to-zero test bit for bit
	always_comb begin
		is_compare = 1'b1;
		case (instr_reg.op)
			crte_pkg::OP_BITS_CLEAR: skip_now = ((data_a_reg & instr_reg.nib) == '0);
			crte_pkg::OP_EQUAL:      skip_now = (diff[crte_pkg::NIB_W-1:0] == '0);
			crte_pkg::OP_UNEQUAL:    skip_now = (diff[crte_pkg::NIB_W-1:0] != '0);
			crte_pkg::OP_GREATER_EQ: skip_now = !borrow;
			crte_pkg::OP_LESS_THAN:  skip_now = borrow;
			default: begin
				skip_now   = 1'b0;
				is_compare = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Write-back selection in the execute cycle
	// ------------------------------------------------------------------
	// Compare opcodes fall to the default and never write memory
	always_comb begin
		exec_we    = 1'b0;
		exec_waddr = m_addr;
		exec_wdata = data_a_reg;
		case (instr_reg.op)
			crte_pkg::OP_LOAD: begin
				exec_we    = 1'b1;
				exec_waddr = r_addr;
			end
			crte_pkg::OP_STORE: begin
				exec_we    = 1'b1;
				exec_waddr = m_addr;
			end
			crte_pkg::OP_ROTATE_RIGHT: begin
				exec_we    = 1'b1;
				exec_waddr = r_addr;
				exec_wdata = {carry_flag, data_a_reg[crte_pkg::NIB_W-1:1]};
			end
			crte_pkg::OP_MOVE_TO_IND: begin
				exec_we    = 1'b1;
				exec_waddr = {ind_row, data_a_reg};
				exec_wdata = mem_q;
			end
			crte_pkg::OP_MOVE_FROM_IND: begin
				exec_we    = 1'b1;
				exec_waddr = m_addr;
				exec_wdata = mem_q;
			end
			default: exec_we = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------
	// Data memory port: the sequencer owns it while busy
	// ------------------------------------------------------------------
	always_comb begin
		mem_req = '0;
		case (state_reg)
			crte_pkg::ST_FETCH_A: begin
				mem_req.en   = 1'b1;
				mem_req.addr = (instr_reg.op == crte_pkg::OP_LOAD || is_compare) ? m_addr
					: r_addr;
			end
			crte_pkg::ST_FETCH_B: begin
				mem_req.en = 1'b1;
				if (instr_reg.op == crte_pkg::OP_MOVE_FROM_IND) begin
					mem_req.addr = {ind_row, mem_q};
				end else begin
					mem_req.addr = m_addr;
				end
			end
			crte_pkg::ST_EXEC: begin
				mem_req.en    = exec_we;
				mem_req.we    = exec_we;
				mem_req.addr  = exec_waddr;
				mem_req.wdata = exec_wdata;
			end
			default: begin
				mem_req.en    = (wr_ok && hit_memdata)
					|| (access && !pwrite && hit_memdata && !rd_pend_reg);
				mem_req.we    = wr_ok && hit_memdata;
				mem_req.addr  = mem_addr_reg;
				mem_req.wdata = pwdata[crte_pkg::NIB_W-1:0];
			end
		endcase
	end

	crte_nibble_mem u_mem (
		.pclk    (pclk),
		.pclk_en (pclk_en),
		.req     (mem_req),
		.rdata   (mem_q)
	);

	// ------------------------------------------------------------------
	// Carry and compare flags: execution wins over a software write
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			carry_flag   <= crte_pkg::FLAGS_RST[crte_pkg::FLG_CARRY];
			compare_flag <= crte_pkg::FLAGS_RST[crte_pkg::FLG_COMPARE];
		end else if (pclk_en) begin
			if (state_reg == crte_pkg::ST_EXEC && instr_reg.op == crte_pkg::OP_ROTATE_RIGHT) begin
				carry_flag <= data_a_reg[0];
			end else if (wr_ok && paddr == crte_pkg::OFS_FLAGS) begin
				carry_flag <= pwdata[crte_pkg::FLG_CARRY];
			end
			if (state_reg == crte_pkg::ST_EXEC && instr_reg.op == crte_pkg::OP_BITS_CLEAR) begin
				compare_flag <= 1'b0;
			end else if (wr_ok && paddr == crte_pkg::OFS_FLAGS) begin
				compare_flag <= pwdata[crte_pkg::FLG_COMPARE];
			end
		end
	end

	// ------------------------------------------------------------------
	// Skip decision: pulse on the skip_pulse output, sticky copy for software
	// ------------------------------------------------------------------
	// Writing 1 to the sticky bit clears it, but a new skip in that cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			skip_pulse_reg <= 1'b0;
			skip_flag_reg  <= 1'b0;
		end else if (pclk_en) begin
			skip_pulse_reg <= (state_reg == crte_pkg::ST_EXEC) && is_compare && skip_now;
			if ((state_reg == crte_pkg::ST_EXEC) && is_compare && skip_now) begin
				skip_flag_reg <= 1'b1;
			end else if (wr_ok && paddr == crte_pkg::OFS_STATUS
				&& pwdata[crte_pkg::STS_SKIP]) begin
				skip_flag_reg <= 1'b0;
			end
		end
	end

	assign skip_pulse = skip_pulse_reg;

endmodule : crte_exec
`default_nettype wire

// ---- logic/crte_nibble_mem.sv ----
// Single-port nibble data memory with registered read data
`timescale 1ns/1ns
`default_nettype none

module crte_nibble_mem (
	input  wire logic                   pclk,
	input  wire logic                   pclk_en,
	input  wire crte_pkg::crte_mem_req_t req,
	output var  logic [crte_pkg::NIB_W-1:0] rdata
);

	logic [crte_pkg::NIB_W-1:0] store_reg [crte_pkg::MEM_DEPTH];

	// ------------------------------------------------------------------
	// Storage: write, or read into the output register
	// ------------------------------------------------------------------
	// Contents are not reset, as in a real RAM
	always_ff @(posedge pclk) begin
		if (pclk_en && req.en) begin
			if (req.we) begin
				store_reg[req.addr] <= req.wdata;
			end else begin
				rdata <= store_reg[req.addr];
			end
		end
	end

endmodule : crte_nibble_mem
`default_nettype wire

// ---- logic/crte_pkg.sv ----
// Package: constants, instruction layout and state codes for the compare/rotate/transfer unit
package crte_pkg;

	// ------------------------------------------------------------------
	// Data memory geometry
	// ------------------------------------------------------------------
	localparam int NIB_W   = 4;
	localparam int ROW_W   = 3;
	localparam int COL_W   = 4;
	localparam int MADDR_W = ROW_W + COL_W;
	localparam int MEM_DEPTH = 128;

	// ------------------------------------------------------------------
	// Operation codes (5-bit field at the top of the word)
	// ------------------------------------------------------------------
	localparam logic [4:0] OP_BITS_CLEAR   = 5'h1f;
	localparam logic [4:0] OP_EQUAL        = 5'h09;
	localparam logic [4:0] OP_UNEQUAL      = 5'h0b;
	localparam logic [4:0] OP_GREATER_EQ   = 5'h19;
	localparam logic [4:0] OP_LESS_THAN    = 5'h1b;
	localparam logic [4:0] OP_ROTATE_RIGHT = 5'h07;
	localparam logic [4:0] OP_LOAD         = 5'h08;
	localparam logic [4:0] OP_STORE        = 5'h18;
	localparam logic [4:0] OP_MOVE_TO_IND  = 5'h0a;
	localparam logic [4:0] OP_MOVE_FROM_IND = 5'h0e;

	// ------------------------------------------------------------------
	// APB register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_INSTR    = 8'h00;
	localparam logic [7:0] OFS_FLAGS    = 8'h04;
	localparam logic [7:0] OFS_INDEX    = 8'h08;
	localparam logic [7:0] OFS_POINTERS = 8'h0c;
	localparam logic [7:0] OFS_STATUS   = 8'h10;
	localparam logic [7:0] OFS_MEM_ADDR = 8'h14;
	localparam logic [7:0] OFS_MEM_DATA = 8'h18;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int FLG_CARRY   = 0;
	localparam int FLG_COMPARE = 1;
	localparam int FLG_INDEX   = 2;
	localparam int FLG_ROWPTR  = 3;
	localparam int STS_BUSY    = 0;
	localparam int STS_SKIP    = 1;
	localparam int PTR_REG_ROW = 0;
	localparam int PTR_MEM_ROW = 4;
	localparam logic [3:0]  FLAGS_RST = 4'h0;
	localparam logic [15:0] INSTR_RST = 16'h0000;

	// Instruction word, most significant field first
	typedef struct packed {
		logic [4:0]       op;
		logic [ROW_W-1:0] row;
		logic [COL_W-1:0] col;
		logic [NIB_W-1:0] nib;
	} crte_instr_t;

	// Data memory port bundle
	typedef struct packed {
		logic               en;
		logic               we;
		logic [MADDR_W-1:0] addr;
		logic [NIB_W-1:0]   wdata;
	} crte_mem_req_t;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0001,
		ST_FETCH_A = 4'b0010,
		ST_FETCH_B = 4'b0100,
		ST_EXEC    = 4'b1000
	} crte_state_t;

endpackage : crte_pkg

// ---- verification/crte_exec_monitor.sv ----
// Checker for the execution unit's APB handshake, busy window and skip pulse
`timescale 1ns/1ns
`default_nettype none

module crte_exec_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        pclk_en,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        busy,
	input wire logic        skip_pulse
);
	// ------------------------------------------------------------------
	// Access decode
	// ------------------------------------------------------------------
	logic acc;
	logic mapped;
	logic ins_wr;
	// A frozen clock enable stalls everything, so only enabled cycles count
	assign acc    = psel && penable && pclk_en;
	assign mapped = (paddr[1:0] == 2'b00) && (paddr <= crte_pkg::OFS_MEM_DATA);
	assign ins_wr = psel && penable && pwrite && (paddr == crte_pkg::OFS_INSTR);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	a_launch_starts_busy: assert property (acc && ins_wr && pready |=> busy)
		else $error("instruction write did not start execution");
	a_busy_three_cycles: assert property (($rose(busy) && pclk_en) ##1 pclk_en ##1 pclk_en
		|-> busy ##1 !busy)
		else $error("execution window is not three cycles");
	a_instr_write_stall: assert property (ins_wr && busy |-> !pready)
		else $error("instruction write accepted while busy");
	a_skip_at_end: assert property (skip_pulse && $past(pclk_en) |-> $past(busy) && !busy)
		else $error("skip pulse outside the end of execution");
	a_unmapped_error: assert property (acc && pready && !mapped
		|-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	a_mapped_no_error: assert property (acc && mapped |-> !pslverr)
		else $error("error response on a mapped register");
	a_mem_read_wait: assert property (psel && !penable && !pwrite
		&& paddr == crte_pkg::OFS_MEM_DATA |=> !pready)
		else $error("memory read answered in its first access cycle");
	a_status_busy_bit: assert property (acc && !pwrite && paddr == crte_pkg::OFS_STATUS
		|-> prdata[0] == busy && prdata[31:2] == 30'h0)
		else $error("status read does not reflect busy");
	a_flags_reserved: assert property (acc && !pwrite && paddr == crte_pkg::OFS_FLAGS
		|-> pready && prdata[31:4] == 28'h0)
		else $error("flag read has stray bits or waits");

	// ------------------------------------------------------------------
	// Coverage of main scenarios
	// ------------------------------------------------------------------
	c_skip: cover property (skip_pulse);
	c_stall: cover property (ins_wr && busy);
	c_refused: cover property (acc && pslverr);
endmodule : crte_exec_monitor

bind crte_exec crte_exec_monitor crte_exec_monitor_inst (
	.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .busy(busy), .skip_pulse(skip_pulse)
);

`default_nettype wire

// ---- verification/crte_exec_tb.sv ----
// Self-checking testbench for the compare, rotate and transfer unit
`timescale 1ns/1ns
`default_nettype none

module testbench;
	localparam logic [4:0] BC = crte_pkg::OP_BITS_CLEAR;
	localparam logic [4:0] EQ = crte_pkg::OP_EQUAL;
	localparam logic [4:0] NE = crte_pkg::OP_UNEQUAL;
	localparam logic [4:0] GE = crte_pkg::OP_GREATER_EQ;
	localparam logic [4:0] LT = crte_pkg::OP_LESS_THAN;
	logic        pclk, presetn, pclk_en, psel, penable, pwrite, pready, pslverr, busy, skip_pulse;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic        e, sp;
	logic [13:0] ct [16];
	int          errors, cmp_count, cycles;

	crte_exec crte_exec_inst (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .busy(busy), .skip_pulse(skip_pulse));

	// ------------------------------------------------------------------
	// Clock, timeout and verdict
	// ------------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// Whole run needs well under two thousand cycles
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			errors++;
			summarize();
		end
	end

	task summarize();
		$display("errors=%0d comparisons=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize

	task check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// ------------------------------------------------------------------
	// APB master: answer and read data taken at the completing rising edge
	// ------------------------------------------------------------------
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rq, output logic re);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Read in the active region, so these are the values before the edge
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, q, e);
	endtask : wr

	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, q, e);
		check(q, exp);
	endtask : rdchk

	task memw(input logic [7:0] a, input logic [3:0] v);
		wr(crte_pkg::OFS_MEM_ADDR, {24'h0, a});
		wr(crte_pkg::OFS_MEM_DATA, {28'h0, v});
	endtask : memw

	task memchk(input logic [7:0] a, input logic [3:0] v);
		wr(crte_pkg::OFS_MEM_ADDR, {24'h0, a});
		rdchk(crte_pkg::OFS_MEM_DATA, {28'h0, v});
	endtask : memchk

	// Launch one instruction, wait for busy to drop, catch the skip pulse
	// A hang here is caught by the bench timeout, which counts it as a mismatch
	task run(input logic [15:0] ins);
		wr(crte_pkg::OFS_INSTR, {16'h0, ins});
		do begin
			@(negedge pclk);
		end while (busy !== 1'b0);
		sp = skip_pulse;
	endtask : run

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		pclk_en = 1'b1;
		errors = 0;
		cmp_count = 0;
		cycles = 0;
		// Op, memory nibble, immediate, expected skip
		ct = '{{BC,4'h6,4'h9,1'b1}, {BC,4'h4,4'h4,1'b0}, {BC,4'h0,4'hf,1'b1}, {EQ,4'h0,4'h0,1'b1},
			{BC,4'h3,4'hf,1'b0}, {EQ,4'h3,4'h0,1'b0}, {EQ,4'h5,4'h5,1'b1}, {EQ,4'h5,4'h6,1'b0},
			{NE,4'h5,4'h6,1'b1}, {NE,4'h5,4'h5,1'b0}, {GE,4'h7,4'h7,1'b1}, {GE,4'h6,4'h7,1'b0},
			{LT,4'h6,4'h7,1'b1}, {LT,4'h7,4'h7,1'b0}, {GE,4'hf,4'h0,1'b1}, {LT,4'h0,4'h1,1'b1}};
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(crte_pkg::OFS_FLAGS, 32'h0);
		rdchk(crte_pkg::OFS_INSTR, 32'h0);
		apb(1'b0, 8'h1c, 32'h0, q, e);
		check({31'h0, e}, 32'h1);
		check(q, 32'h0);
		// Compare family: skip decision, compare flag cleared by bits-clear only, memory left alone
		for (int i = 0; i < 16; i++) begin
			memw(8'h25, ct[i][8:5]);
			wr(crte_pkg::OFS_FLAGS, 32'h3);
			run({ct[i][13:9], 3'h2, 4'h5, ct[i][4:1]});
			check({31'h0, sp}, {31'h0, ct[i][0]});
			rdchk(crte_pkg::OFS_STATUS, {30'h0, ct[i][0], 1'b0});
			rdchk(crte_pkg::OFS_FLAGS, (ct[i][13:9] == BC) ? 32'h1 : 32'h3);
			memchk(8'h25, ct[i][8:5]);
			wr(crte_pkg::OFS_STATUS, 32'h2);
		end
		// Rotate through carry, general register row one
		wr(crte_pkg::OFS_POINTERS, 32'h1);
		memw(8'h13, 4'h8);
		wr(crte_pkg::OFS_FLAGS, 32'h1);
		run({crte_pkg::OP_ROTATE_RIGHT, 3'h0, 4'h0, 4'h3});
		memchk(8'h13, 4'hc);
		rdchk(crte_pkg::OFS_FLAGS, 32'h0);
		memw(8'h13, 4'h5);
		run({crte_pkg::OP_ROTATE_RIGHT, 3'h0, 4'h0, 4'h3});
		memchk(8'h13, 4'h2);
		rdchk(crte_pkg::OFS_FLAGS, 32'h1);
		// Load then store back to back: second write stalls until the first ends
		wr(crte_pkg::OFS_POINTERS, 32'h0);
		wr(crte_pkg::OFS_FLAGS, 32'h0);
		memw(8'h2f, 4'ha);
		memw(8'h6f, 4'h7);
		wr(crte_pkg::OFS_INSTR, {16'h0, crte_pkg::OP_LOAD, 3'h2, 4'hf, 4'h3});
		run({crte_pkg::OP_STORE, 3'h1, 4'h8, 4'h3});
		memchk(8'h03, 4'ha);
		memchk(8'h18, 4'ha);
		// Indexed load and store: operand address is index ORed with field
		wr(crte_pkg::OFS_INDEX, 32'h40);
		wr(crte_pkg::OFS_FLAGS, 32'h4);
		run({crte_pkg::OP_LOAD, 3'h2, 4'hf, 4'h3});
		memchk(8'h03, 4'h7);
		run({crte_pkg::OP_STORE, 3'h1, 4'h8, 4'h3});
		memchk(8'h58, 4'h7);
		memchk(8'h18, 4'ha);
		// Indirect move, same row first, then row from the pointer
		wr(crte_pkg::OFS_INDEX, 32'h0);
		wr(crte_pkg::OFS_FLAGS, 32'h0);
		memw(8'h00, 4'hf);
		memw(8'h20, 4'h6);
		run({crte_pkg::OP_MOVE_TO_IND, 3'h2, 4'h0, 4'h0});
		memchk(8'h2f, 4'h6);
		wr(crte_pkg::OFS_POINTERS, 32'h30);
		wr(crte_pkg::OFS_FLAGS, 32'h8);
		memw(8'h20, 4'hb);
		run({crte_pkg::OP_MOVE_TO_IND, 3'h2, 4'h0, 4'h0});
		memchk(8'h3f, 4'hb);
		memchk(8'h2f, 4'h6);
		summarize();
	end
endmodule : testbench

`default_nettype wire
